// file: asu_core.sv
// Asynchronous serial unit: register port, transmitter, receiver and interrupt logic.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
module asu_core
  import asu_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic serial_in_pin_in,
  output logic serial_out_out,
  output logic irq_out
);

  // Odd-ones detector over the active character bits.
  function automatic logic odd_ones(input logic [7:0] data, input logic len8);
    odd_ones = ^(len8 ? data : {1'b0, data[6:0]});
  endfunction : odd_ones

  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] txbuf_ff, nxt_txbuf;
  logic txfull_ff, nxt_txfull;
  logic [15:0] div_ff, nxt_div;
  logic [2:0] irq_st_ff, nxt_irq_st;
  logic [2:0] irq_msk_ff, nxt_irq_msk;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic irq_ff, nxt_irq;
  asu_tx_state_t tx_state_ff, nxt_tx_state;
  logic [15:0] tx_cnt_ff, nxt_tx_cnt;
  logic [2:0] tx_bit_ff, nxt_tx_bit;
  logic [7:0] tx_shift_ff, nxt_tx_shift;
  logic tx_par_ff, nxt_tx_par;
  logic tx_stop2_ff, nxt_tx_stop2;
  logic serial_out_ff, nxt_serial_out;
  logic rx_sync1_ff, rx_sync2_ff;
  asu_rx_state_t rx_state_ff, nxt_rx_state;
  logic [15:0] rx_cnt_ff, nxt_rx_cnt;
  logic [2:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_shift_ff, nxt_rx_shift;
  logic rx_par_ff, nxt_rx_par;
  logic [7:0] rx_data_ff, nxt_rx_data;
  logic [2:0] rx_err_ff, nxt_rx_err;
  logic rx_full_ff, nxt_rx_full;
  logic tx_load, rx_done_ev, rx_err_ev;

  wire logic power = mode_ff[MODE_POWER];
  wire logic tx_run = power & mode_ff[MODE_TXE];
  wire logic rx_run = power & mode_ff[MODE_RXE];
  wire logic [1:0] par_mode = {mode_ff[MODE_PS_HI], mode_ff[MODE_PS_LO]};
  wire logic len8 = mode_ff[MODE_CL];
  wire logic [2:0] last_bit = len8 ? 3'h7 : 3'h6;
  wire logic tx_tick = (tx_cnt_ff == 16'h0000);
  wire logic rx_tick = (rx_cnt_ff == 16'h0000);
  wire logic wr_txbuf = wr_en_in & (addr_in == ADDR_TXBUF);
  wire logic rd_rxdata = rd_en_in & (addr_in == ADDR_RXDATA);
  wire logic rd_rxerr = rd_en_in & (addr_in == ADDR_RXERR);

  // Register file, read mux and interrupt; hardware events win over write-one-to-clear.
  always_comb begin
    nxt_mode = mode_ff;
    nxt_txbuf = txbuf_ff;
    nxt_div = div_ff;
    nxt_irq_msk = irq_msk_ff;
    nxt_irq_st = irq_st_ff;
    nxt_rd_data = 8'h00;
    if (wr_en_in) begin
      unique case (addr_in)
        ADDR_MODE: nxt_mode = wr_data_in;
        ADDR_TXBUF: nxt_txbuf = wr_data_in;
        ADDR_IRQST: nxt_irq_st = irq_st_ff & ~wr_data_in[2:0];
        ADDR_IRQMSK: nxt_irq_msk = wr_data_in[2:0];
        ADDR_DIVLO: nxt_div = {div_ff[15:8], wr_data_in};
        ADDR_DIVHI: nxt_div = {wr_data_in, div_ff[7:0]};
        default: nxt_mode = mode_ff;
      endcase
    end
    nxt_irq_st[IRQ_TXBUF] = nxt_irq_st[IRQ_TXBUF] | tx_load;
    nxt_irq_st[IRQ_RXDONE] = nxt_irq_st[IRQ_RXDONE] | rx_done_ev;
    nxt_irq_st[IRQ_RXERR] = nxt_irq_st[IRQ_RXERR] | rx_err_ev;
    nxt_irq = |(nxt_irq_st & nxt_irq_msk);
    if (rd_en_in) begin
      unique case (addr_in)
        ADDR_MODE: nxt_rd_data = mode_ff;
        ADDR_TXSTAT: nxt_rd_data = {6'h00, txfull_ff, tx_state_ff != TX_IDLE};
        ADDR_RXDATA: nxt_rd_data = rx_data_ff;
        ADDR_RXERR: nxt_rd_data = {5'h00, rx_err_ff};
        ADDR_IRQST: nxt_rd_data = {5'h00, irq_st_ff};
        ADDR_IRQMSK: nxt_rd_data = {5'h00, irq_msk_ff};
        ADDR_DIVLO: nxt_rd_data = div_ff[7:0];
        ADDR_DIVHI: nxt_rd_data = div_ff[15:8];
        default: nxt_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_ff <= MODE_RST;
      txbuf_ff <= 8'h00;
      div_ff <= DIV_RST;
      irq_msk_ff <= IRQ_MSK_RST;
      irq_st_ff <= 3'h0;
      rd_data_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      txbuf_ff <= nxt_txbuf;
      div_ff <= nxt_div;
      irq_msk_ff <= nxt_irq_msk;
      irq_st_ff <= nxt_irq_st;
      rd_data_ff <= nxt_rd_data;
      irq_ff <= nxt_irq;
    end
  end

  // Transmitter. Clearing power acts as a soft reset and also drops a pending byte.
  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_cnt = tx_tick ? div_ff : tx_cnt_ff - 16'h0001;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_stop2 = tx_stop2_ff;
    nxt_serial_out = serial_out_ff;
    tx_load = 1'b0;
    unique case (tx_state_ff)
      TX_IDLE: begin
        nxt_serial_out = 1'b1;
        tx_load = tx_run & txfull_ff;
      end
      TX_START: if (tx_tick) begin
        nxt_tx_state = TX_DATA;
        nxt_tx_bit = 3'h0;
        nxt_serial_out = tx_shift_ff[0];
      end
      TX_DATA: if (tx_tick) begin
        if (tx_bit_ff == last_bit) begin
          nxt_tx_state = (par_mode == PAR_NONE) ? TX_STOP : TX_PAR;
          nxt_serial_out = (par_mode == PAR_NONE) ? 1'b1 : tx_par_ff;
        end else begin
          nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
          nxt_tx_bit = tx_bit_ff + 3'h1;
          nxt_serial_out = tx_shift_ff[1];
        end
      end
      TX_PAR: if (tx_tick) begin
        nxt_tx_state = TX_STOP;
        nxt_serial_out = 1'b1;
      end
      TX_STOP: if (tx_tick) begin
        if (tx_stop2_ff) begin
          nxt_tx_stop2 = 1'b0;
        end else if (tx_run & txfull_ff) begin
          // Queued byte waits out the extra gap before its start bit.
          nxt_tx_state = TX_GAP;
          nxt_tx_cnt = TX_GAP_CLKS - 16'h0001;
        end else begin
          nxt_tx_state = TX_IDLE;
        end
      end
      TX_GAP: tx_load = tx_tick;
      default: nxt_tx_state = TX_IDLE;
    endcase
    if (tx_load) begin
      // Byte moves into the shifter and frees the holding buffer.
      nxt_tx_state = TX_START;
      nxt_tx_shift = txbuf_ff;
      nxt_tx_cnt = div_ff;
      nxt_tx_stop2 = mode_ff[MODE_SL];
      nxt_tx_par = (par_mode == PAR_ZERO) ? 1'b0 :
                   (odd_ones(txbuf_ff, len8) ^ (par_mode == PAR_ODD));
      nxt_serial_out = 1'b0;
    end
    // Holding full flag; a write in the load cycle still sets it.
    nxt_txfull = (txfull_ff & ~tx_load) | wr_txbuf;
    if (!tx_run) begin
      nxt_tx_state = TX_IDLE;
      nxt_serial_out = 1'b1;
    end
    if (!power) begin
      nxt_txfull = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_state_ff <= TX_IDLE;
      tx_cnt_ff <= 16'h0000;
      tx_bit_ff <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      tx_stop2_ff <= 1'b0;
      serial_out_ff <= 1'b1;
      txfull_ff <= 1'b0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_shift_ff <= nxt_tx_shift;
      tx_par_ff <= nxt_tx_par;
      tx_stop2_ff <= nxt_tx_stop2;
      serial_out_ff <= nxt_serial_out;
      txfull_ff <= nxt_txfull;
    end
  end

  // Receiver. Start is detected on level, not on an edge, so enabling on a low line starts a frame.
  always_comb begin
    nxt_rx_state = rx_state_ff;
    nxt_rx_cnt = rx_tick ? div_ff : rx_cnt_ff - 16'h0001;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_shift = rx_shift_ff;
    nxt_rx_par = rx_par_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_err = rd_rxerr ? 3'h0 : rx_err_ff;
    nxt_rx_full = rx_full_ff & ~rd_rxdata;
    rx_done_ev = 1'b0;
    rx_err_ev = 1'b0;
    unique case (rx_state_ff)
      RX_IDLE: if (!rx_sync2_ff) begin
        nxt_rx_state = RX_START;
        nxt_rx_cnt = {1'b0, div_ff[15:1]};
      end
      RX_START: if (rx_tick) begin
        nxt_rx_state = rx_sync2_ff ? RX_IDLE : RX_DATA;
        nxt_rx_bit = 3'h0;
      end
      RX_DATA: if (rx_tick) begin
        nxt_rx_bit = rx_bit_ff + 3'h1;
        nxt_rx_shift = {rx_sync2_ff, rx_shift_ff[7:1]};
        if (rx_bit_ff == last_bit) begin
          nxt_rx_state = (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
          if (!len8) begin
            nxt_rx_shift = {1'b0, rx_sync2_ff, rx_shift_ff[7:2]};
          end
        end
      end
      RX_PAR: if (rx_tick) begin
        nxt_rx_state = RX_STOP;
        nxt_rx_par = rx_sync2_ff;
      end
      RX_STOP: if (rx_tick) begin
        // Only the first stop bit is sampled whatever the stop length setting.
        nxt_rx_state = RX_IDLE;
        nxt_rx_data = rx_shift_ff;
        nxt_rx_full = 1'b1;
        nxt_rx_err[RXE_FRAMING] = nxt_rx_err[RXE_FRAMING] | ~rx_sync2_ff;
        nxt_rx_err[RXE_OVERRUN] = nxt_rx_err[RXE_OVERRUN] | rx_full_ff;
        // No check in none or zero mode; odd and even compare the total count of ones.
        nxt_rx_err[RXE_PARITY] = nxt_rx_err[RXE_PARITY] | (par_mode[1] &
          ((odd_ones(rx_shift_ff, len8) ^ rx_par_ff) == par_mode[0]));
        rx_err_ev = ~rx_sync2_ff | rx_full_ff | (par_mode[1] &
          ((odd_ones(rx_shift_ff, len8) ^ rx_par_ff) == par_mode[0]));
        rx_done_ev = ~rx_err_ev | mode_ff[MODE_ISRM];
        rx_err_ev = rx_err_ev & ~mode_ff[MODE_ISRM];
      end
      default: nxt_rx_state = RX_IDLE;
    endcase
    if (!rx_run) begin
      nxt_rx_state = RX_IDLE;
    end
    if (!power) begin
      nxt_rx_err = 3'h0;
      nxt_rx_full = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_sync1_ff <= 1'b1;
      rx_sync2_ff <= 1'b1;
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_par_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx_err_ff <= 3'h0;
      rx_full_ff <= 1'b0;
    end else begin
      rx_sync1_ff <= serial_in_pin_in;
      rx_sync2_ff <= rx_sync1_ff;
      rx_state_ff <= nxt_rx_state;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_shift_ff <= nxt_rx_shift;
      rx_par_ff <= nxt_rx_par;
      rx_data_ff <= nxt_rx_data;
      rx_err_ff <= nxt_rx_err;
      rx_full_ff <= nxt_rx_full;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign serial_out_out = serial_out_ff;
  assign irq_out = irq_ff;

  // Checks on gap, start detection, stop sampling, parity and the full flag.
  sequence s_stop_end_queued;
    tx_state_ff == TX_STOP && tx_tick && !tx_stop2_ff && txfull_ff;
  endsequence
  sequence s_gap_then_start;
    (tx_state_ff == TX_GAP) [*2] ##1 (tx_state_ff == TX_START && !serial_out_ff);
  endsequence
  property p_tx_gap;
    @(posedge mclk_in) disable iff (!rst_b_in || !tx_run)
      s_stop_end_queued |=> s_gap_then_start;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("Back-to-back gap is not two clocks.");
  property p_rx_level_start;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (rx_run && rx_state_ff == RX_IDLE && !rx_sync2_ff) ##1 rx_run |-> rx_state_ff == RX_START;
  endproperty
  a_rx_level_start: assert property (p_rx_level_start) else $error("Low line not taken as start.");
  property p_rx_one_stop;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (rx_state_ff == RX_STOP && rx_tick) |=> (rx_state_ff == RX_IDLE && rx_full_ff);
  endproperty
  a_rx_one_stop: assert property (p_rx_one_stop) else $error("Receiver waited past one stop bit.");
  property p_parity_flag;
    @(posedge mclk_in) disable iff (!rst_b_in || !power)
      (rx_state_ff == RX_STOP && rx_tick && !rd_rxerr && !rx_err_ff[RXE_PARITY] && rx_run) |=>
        (rx_err_ff[RXE_PARITY] == ($past(par_mode[1]) &&
         (($past(odd_ones(rx_shift_ff, len8)) ^ $past(rx_par_ff)) == $past(par_mode[0]))));
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("Parity flag disagrees with mode.");
  property p_full_flag;
    @(posedge mclk_in) disable iff (!rst_b_in)
      power && (wr_txbuf || tx_load) |=> txfull_ff == $past(wr_txbuf);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("Holding full flag wrong.");

endmodule : asu_core

// file: asu_pkg.sv
// Package with register map, field positions, reset values and state types of the serial unit.
package asu_pkg;
  // Register addresses on the plain register port.
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_TXBUF = 4'h1;
  localparam logic [3:0] ADDR_TXSTAT = 4'h2;
  localparam logic [3:0] ADDR_RXDATA = 4'h3;
  localparam logic [3:0] ADDR_RXERR = 4'h4;
  localparam logic [3:0] ADDR_IRQST = 4'h5;
  localparam logic [3:0] ADDR_IRQMSK = 4'h6;
  localparam logic [3:0] ADDR_DIVLO = 4'h7;
  localparam logic [3:0] ADDR_DIVHI = 4'h8;
  // Field positions of mode_control_reg.
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_CL = 2;
  localparam int MODE_SL = 1;
  localparam int MODE_ISRM = 0;
  // Field positions of tx_status_reg.
  localparam int TXST_FULL = 1;
  localparam int TXST_BUSY = 0;
  // Field positions of rx_error_status_reg.
  localparam int RXE_PARITY = 2;
  localparam int RXE_FRAMING = 1;
  localparam int RXE_OVERRUN = 0;
  // Field positions of the interrupt status and mask registers.
  localparam int IRQ_TXBUF = 0;
  localparam int IRQ_RXDONE = 1;
  localparam int IRQ_RXERR = 2;
  // Reset values.
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h01B1;
  localparam logic [2:0] IRQ_MSK_RST = 3'h0;
  // Extra gap in unit clocks between frames sent back to back.
  localparam logic [15:0] TX_GAP_CLKS = 16'h0002;
  // Parity modes.
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_PAR = 3'h2, TX_STOP = 3'h6, TX_GAP = 3'h7
  } asu_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2, RX_STOP = 3'h6
  } asu_rx_state_t;
endpackage : asu_pkg

// file: asu_remote_node.sv
// Behavioural model of the far serial node that talks to the unit.
module asu_remote_node #(
  parameter int BIT_CLKS = 4
) (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic hold_low_in,
  output logic line_out
);
  logic drv_ff = 1'b1;
  logic [7:0] rx_byte_ff = 8'h00;
  int rx_cnt = 0;
  int start_gap = 0;
  int cyc = 0;
  int last_start = 0;

  // A held-low line models a node that keeps the line low before reception starts.
  assign line_out = hold_low_in ? 1'b0 : drv_ff;

  // Cycle count used to time the spacing of start bits.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
  end

  // Receiver samples mid-bit; it measures start-to-start spacing in unit clocks.
  always begin
    @(negedge line_in);
    start_gap = cyc - last_start;
    last_start = cyc;
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_in);
      rx_byte_ff[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk_in);
    rx_cnt = rx_cnt + 1;
  end

  // Sends start, data LSB first, optional parity and one stop bit, then idles high.
  task automatic send(input logic [7:0] d, input logic par_en, input logic par_bit);
    logic [10:0] f;
    f = {1'b1, par_en ? par_bit : 1'b1, d, 1'b0};
    for (int i = 0; i < (par_en ? 11 : 10); i++) begin
      drv_ff <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask : send
endmodule : asu_remote_node

// file: tb_asu_core.sv
// Self-checking testbench of the serial unit against a remote node model.
module tb_asu_core
  import asu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hold_low = 1'b0;
  logic [7:0] rdat;
  logic sin;
  logic sout;
  logic irq;
  int failures = 0;
  int tests_run = 0;

  // Free-running 50 MHz unit clock.
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  asu_core i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdat), .serial_in_pin_in(sin),
    .serial_out_out(sout), .irq_out(irq));

  asu_remote_node #(.BIT_CLKS(4)) i_node (.clk_in(mclk_in), .line_in(sout),
    .hold_low_in(hold_low), .line_out(sin));

  // Bus cycles; each leaves one idle edge so a strobe is never set twice in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    @(posedge mclk_in);
    wr_en <= 1'b0;
  endtask : wr

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk

  // Read data are taken mid-cycle, once the answer has settled.
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk_in);
    rd_en <= 1'b0;
    @(negedge mclk_in);
    chk(n, e, rdat);
  endtask : rc

  task automatic wait_rx(input int n);
    for (int i = 0; i < 2000 && i_node.rx_cnt < n; i++) @(posedge mclk_in);
    chk("frame count", 8'(n), 8'(i_node.rx_cnt));
  endtask : wait_rx

  task automatic t_reset();
    chk("serial idle", 8'h01, {7'h00, sout});
    chk("irq idle", 8'h00, {7'h00, irq});
    rc("mode", ADDR_MODE, MODE_RST);
    rc("mask", ADDR_IRQMSK, {5'h00, IRQ_MSK_RST});
    rc("div lo", ADDR_DIVLO, DIV_RST[7:0]);
    rc("div hi", ADDR_DIVHI, DIV_RST[15:8]);
    rc("unmapped", 4'hF, 8'h00);
    wr(ADDR_DIVLO, 8'h03);
    wr(ADDR_DIVHI, 8'h00);
  endtask : t_reset

  // Two buffered bytes: the flag tracks the buffer and frames are spaced by the gap.
  task automatic t_tx();
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_TXBUF, 8'h5A);
    rc("full after write", ADDR_TXSTAT, 8'h02);
    wr(ADDR_MODE, 8'hC4);
    rc("full after move", ADDR_TXSTAT, 8'h01);
    wr(ADDR_TXBUF, 8'hA3);
    wait_rx(1);
    chk("first byte", 8'h5A, i_node.rx_byte_ff);
    wait_rx(2);
    chk("second byte", 8'hA3, i_node.rx_byte_ff);
    chk("start gap", 8'h28 + TX_GAP_CLKS[7:0], i_node.start_gap[7:0]);
    // A single frame as a bus node would send it: only once the last one is done.
    repeat (2) @(posedge mclk_in);
    rc("idle before single", ADDR_TXSTAT, 8'h00);
    wr(ADDR_TXBUF, 8'hC3);
    wait_rx(3);
    chk("single byte", 8'hC3, i_node.rx_byte_ff);
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_MODE, 8'h04);
  endtask : t_tx

  // Two-stop setting, but frames arrive with one stop: no framing error may appear.
  task automatic t_rx();
    wr(ADDR_MODE, 8'h86);
    wr(ADDR_IRQMSK, 8'h02);
    wr(ADDR_IRQST, 8'h07);
    wr(ADDR_MODE, 8'hA6);
    i_node.send(8'h3C, 1'b0, 1'b0);
    i_node.send(8'h96, 1'b0, 1'b0);
    repeat (8) @(posedge mclk_in);
    chk("irq raised", 8'h01, {7'h00, irq});
    rc("irq status", ADDR_IRQST, 8'h06);
    rc("rx data", ADDR_RXDATA, 8'h96);
    rc("rx error", ADDR_RXERR, 8'h01);
    wr(ADDR_IRQST, 8'h02);
    @(negedge mclk_in);
    chk("irq masked", 8'h00, {7'h00, irq});
    rc("irq left", ADDR_IRQST, 8'h04);
    wr(ADDR_IRQST, 8'h04);
    rc("irq cleared", ADDR_IRQST, 8'h00);
    // Routing bit changed with reception off; an overrun then reports as rx done.
    wr(ADDR_MODE, 8'h86);
    wr(ADDR_MODE, 8'h87);
    wr(ADDR_MODE, 8'hA7);
    i_node.send(8'h69, 1'b0, 1'b0);
    i_node.send(8'hE1, 1'b0, 1'b0);
    repeat (8) @(posedge mclk_in);
    chk("routed irq", 8'h01, {7'h00, irq});
    rc("routed status", ADDR_IRQST, 8'h02);
    rc("routed error", ADDR_RXERR, 8'h01);
    rc("routed data", ADDR_RXDATA, 8'hE1);
    wr(ADDR_IRQST, 8'h02);
    wr(ADDR_MODE, 8'h87);
    wr(ADDR_MODE, 8'h86);
  endtask : t_rx

  // Every parity mode receives a frame; its parity bit, sent in all modes but none, is wrong for odd and even.
  task automatic t_parity();
    logic [7:0] md;
    for (int m = 0; m < 4; m++) begin
      md = {3'b100, m[1:0], 3'b100};
      wr(ADDR_MODE, md);
      wr(ADDR_MODE, md | 8'h20);
      i_node.send(8'h55, m != 0, m != 2);
      repeat (8) @(posedge mclk_in);
      rc("parity data", ADDR_RXDATA, 8'h55);
      rc("parity flag", ADDR_RXERR, (m >= 2) ? 8'h04 : 8'h00);
      // Reception goes off first so the next parity change meets a quiet unit.
      wr(ADDR_MODE, md);
    end
  endtask : t_parity

  // Long bits leave a wide margin: the line rises between data bits 1 and 2.
  task automatic t_low_enable();
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_DIVLO, 8'h0F);
    hold_low <= 1'b1;
    wr(ADDR_MODE, 8'hA4);
    repeat (48) @(posedge mclk_in);
    hold_low <= 1'b0;
    repeat (160) @(posedge mclk_in);
    rc("rx from low", ADDR_RXDATA, 8'hFC);
    rc("rx low errors", ADDR_RXERR, 8'h00);
  endtask : t_low_enable

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // The whole run needs under a thousand cycles; the watchdog allows far more.
  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    give_verdict();
  end

  // Main sequence after three cycles of reset.
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_parity();
    t_low_enable();
    give_verdict();
  end
endmodule : tb_asu_core
